// >>> logic/prf_core.sv
// Procedure register file with frames, scoreboard and state save port
// Summary of operation
// - Sixteen 32-bit global registers kept across calls and returns.
// - Top global register holds the frame pointer; others general purpose.
// - Four 80-bit float registers kept across procedure boundaries.
// - Float registers are reached only by the float ports.
// - Single or double results are widened to extended before storing.
// - On suspend, all global and float registers stream out for saving.
// - A call saves caller locals while fewer than DEPTH frames are stacked and gives the callee a fresh set.
// - Local zero, one, two hold previous frame, stack, return pointers.
// - Local accesses take the same latency as global accesses.
// - Least significant word goes to the named register, upward after.
// - Misaligned groups give undefined data; here the index wraps.
// - Issued long operations mark their destination group busy.
// - Independent instructions proceed while busy registers are pending.
// - Pending loads of three to nine cycles overlap short instructions.
module prf_core #(
  parameter int unsigned DEPTH = prf_pkg::FRAME_DEPTH
) (
  input wire logic core_clk_i,
  input wire logic rst_b_i,
  input wire prf_pkg::prf_ref_t src_a_i,
  input wire prf_pkg::prf_ref_t src_b_i,
  input wire prf_pkg::prf_iwr_t iwr_i,
  input wire logic [1:0] fsrc_idx_i,
  input wire prf_pkg::prf_fwr_t fwr_i,
  input wire prf_pkg::prf_ref_t sb_set_i,
  input wire logic fsb_set_i,
  input wire logic [1:0] fsb_idx_i,
  input wire logic call_i,
  input wire logic ret_i,
  input wire logic [31:0] call_sp_i,
  input wire logic [31:0] call_rip_i,
  input wire logic suspend_i,
  output logic [4*prf_pkg::WORD_W-1:0] src_a_o,
  output logic [4*prf_pkg::WORD_W-1:0] src_b_o,
  output logic [prf_pkg::FLT_W-1:0] fsrc_o,
  output logic stall_o,
  output logic [prf_pkg::NUM_INT-1:0] busy_o,
  output logic save_valid_o,
  output logic [4:0] save_idx_o,
  output logic [prf_pkg::FLT_W-1:0] save_data_o,
  output logic frame_ovf_o
);
  localparam int unsigned W = prf_pkg::WORD_W;
  localparam int unsigned PW = $clog2(DEPTH + 1);

  logic [W-1:0] glob_q [prf_pkg::NUM_GLOBAL];
  logic [W-1:0] loc_q [prf_pkg::NUM_LOCAL];
  logic [W-1:0] stack_q [DEPTH][prf_pkg::NUM_LOCAL];
  logic [PW-1:0] depth_q;
  logic [prf_pkg::FLT_W-1:0] flt_q [prf_pkg::NUM_FLOAT];
  logic [prf_pkg::NUM_INT-1:0] sb_q;
  logic [prf_pkg::NUM_FLOAT-1:0] fsb_q;
  logic [prf_pkg::NUM_INT-1:0] set_mask;
  logic [prf_pkg::NUM_INT-1:0] clr_mask;
  logic [prf_pkg::NUM_INT-1:0] need_mask;
  logic [prf_pkg::FLT_W-1:0] fwr_ext;
  logic [4:0] save_cnt_q;
  logic save_act_q;

  default clocking @(posedge core_clk_i);
  endclocking
  default disable iff (!rst_b_i);

  // Mask of the registers covered by a group; index wraps within a bank
  function automatic logic [31:0] grp_mask(input prf_pkg::prf_ref_t r);
    logic [31:0] m;
    logic [4:0] k;
    m = 32'h0;
    k = 5'h0;
    if (r.valid)
    begin
      for (int i = 0; i < 4; i++)
      begin
        if (i <= int'(r.len_m1))
        begin
          k = {r.idx[4], r.idx[3:0] + 4'(i)};
          m[k] = 1'b1;
        end
      end
    end
    return m;
  endfunction

  function automatic logic [W-1:0] rd_word(input logic [4:0] k,
    input logic [W-1:0] g [16], input logic [W-1:0] l [16]);
    return k[4] ? l[k[3:0]] : g[k[3:0]];
  endfunction

  always_comb
  begin
    set_mask = grp_mask(sb_set_i);
    clr_mask = grp_mask(prf_pkg::prf_ref_t'({iwr_i.valid, iwr_i.idx,
      iwr_i.len_m1}));
    need_mask = grp_mask(src_a_i) | grp_mask(src_b_i) | set_mask;
  end

  // Stall only on overlap with pending registers, so others go on
  // A read in the write-back cycle still stalls: the data lands at that edge
  always_ff @(posedge core_clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
      stall_o <= 1'b0;
    else
      stall_o <= |(need_mask & sb_q) | fsb_q[fsrc_idx_i] |
        (fsb_set_i & fsb_q[fsb_idx_i]);
  end

  // Set wins over clear so a reissue in the completion cycle stays busy
  always_ff @(posedge core_clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      sb_q <= prf_pkg::SB_RST;
      fsb_q <= prf_pkg::FLT_BUSY_RST;
    end
    else
    begin
      sb_q <= (sb_q & ~clr_mask) | set_mask;
      if (fwr_i.valid)
        fsb_q[fwr_i.idx] <= 1'b0;
      if (fsb_set_i)
        fsb_q[fsb_idx_i] <= 1'b1;
    end
  end

  always_ff @(posedge core_clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
      busy_o <= prf_pkg::SB_RST;
    else
      busy_o <= (sb_q & ~clr_mask) | set_mask;
  end

  // Widen to extended: sign, rebiased exponent, explicit integer bit
  always_comb
  begin
    fwr_ext = fwr_i.data;
    unique case (fwr_i.fmt)
      prf_pkg::PRF_FMT_SINGLE:
        fwr_ext = {fwr_i.data[31], 15'(fwr_i.data[30:23]) +
          prf_pkg::SGL_BIAS, 1'b1, fwr_i.data[22:0], 40'h0};
      prf_pkg::PRF_FMT_DOUBLE:
        fwr_ext = {fwr_i.data[63], 15'(fwr_i.data[62:52]) +
          prf_pkg::EXT_BIAS, 1'b1, fwr_i.data[51:0], 11'h0};
      default:
        fwr_ext = fwr_i.data;
    endcase
  end

  // Float bank is touched only through the float ports
  always_ff @(posedge core_clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      for (int i = 0; i < prf_pkg::NUM_FLOAT; i++)
        flt_q[i] <= prf_pkg::FLT_RST;
    end
    else if (fwr_i.valid)
      flt_q[fwr_i.idx] <= fwr_ext;
  end

  // Globals: least significant word at the base, upward after
  always_ff @(posedge core_clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      for (int i = 0; i < prf_pkg::NUM_GLOBAL; i++)
        glob_q[i] <= prf_pkg::WORD_RST;
    end
    else if (iwr_i.valid && !iwr_i.idx[4])
    begin
      for (int i = 0; i < 4; i++)
        if (i <= int'(iwr_i.len_m1))
          glob_q[4'(iwr_i.idx[3:0] + 4'(i))] <= iwr_i.data[i*W +: W];
    end
  end

  // Locals and frame stack; a call pushes unless the stack is full, and seeds linkage words
  always_ff @(posedge core_clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      depth_q <= '0;
      frame_ovf_o <= 1'b0;
      for (int i = 0; i < prf_pkg::NUM_LOCAL; i++)
        loc_q[i] <= prf_pkg::WORD_RST;
      for (int i = 0; i < DEPTH; i++)
        stack_q[i] <= '{default: prf_pkg::WORD_RST};
    end
    else if (call_i)
    begin
      if (depth_q < PW'(DEPTH))
      begin
        stack_q[depth_q[$clog2(DEPTH)-1:0]] <= loc_q;
        depth_q <= depth_q + PW'(1);
      end
      else
        frame_ovf_o <= 1'b1;
      for (int i = 0; i < prf_pkg::NUM_LOCAL; i++)
        loc_q[i] <= prf_pkg::WORD_RST;
      loc_q[0] <= glob_q[prf_pkg::GLOBAL_TOP_IDX[3:0]];
      loc_q[1] <= call_sp_i;
      loc_q[2] <= call_rip_i;
    end
    else if (ret_i && depth_q != '0)
    begin
      loc_q <= stack_q[depth_q[$clog2(DEPTH)-1:0] - 1'b1];
      depth_q <= depth_q - PW'(1);
    end
    else if (iwr_i.valid && iwr_i.idx[4])
    begin
      for (int i = 0; i < 4; i++)
        if (i <= int'(iwr_i.len_m1))
          loc_q[4'(iwr_i.idx[3:0] + 4'(i))] <= iwr_i.data[i*W +: W];
    end
  end

  // Read ports, same one-cycle registered path for both banks
  always_ff @(posedge core_clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      src_a_o <= '0;
      src_b_o <= '0;
      fsrc_o <= prf_pkg::FLT_RST;
    end
    else
    begin
      for (int i = 0; i < 4; i++)
      begin
        src_a_o[i*W +: W] <= rd_word({src_a_i.idx[4],
          4'(src_a_i.idx[3:0] + 4'(i))}, glob_q, loc_q);
        src_b_o[i*W +: W] <= rd_word({src_b_i.idx[4],
          4'(src_b_i.idx[3:0] + 4'(i))}, glob_q, loc_q);
      end
      fsrc_o <= flt_q[fsrc_idx_i];
    end
  end

  // Suspend streams globals 0..15 then floats 16..19 one per cycle
  always_ff @(posedge core_clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      save_act_q <= 1'b0;
      save_cnt_q <= 5'h0;
      save_valid_o <= 1'b0;
      save_idx_o <= 5'h0;
      save_data_o <= prf_pkg::FLT_RST;
    end
    else
    begin
      save_valid_o <= save_act_q;
      save_idx_o <= save_cnt_q;
      save_data_o <= save_cnt_q[4] ? flt_q[save_cnt_q[1:0]] :
        prf_pkg::FLT_W'(glob_q[save_cnt_q[3:0]]);
      if (suspend_i && !save_act_q)
      begin
        save_act_q <= 1'b1;
        save_cnt_q <= 5'h0;
      end
      else if (save_act_q)
      begin
        save_cnt_q <= save_cnt_q + 5'h1;
        if (save_cnt_q == prf_pkg::SAVE_LAST)
          save_act_q <= 1'b0;
      end
    end
  end

  AST_SB_CLEARS: assert property (iwr_i.valid && !sb_set_i.valid |=>
    (busy_o & $past(clr_mask)) == '0) else $error("written group busy");
  AST_SB_SETS: assert property (sb_set_i.valid |=>
    (busy_o & $past(set_mask)) == $past(set_mask))
    else $error("issued group not marked busy");
  AST_NO_FALSE_STALL: assert property (sb_q == '0 && fsb_q == '0 |=>
    !stall_o) else $error("stall with empty scoreboard");
  AST_FSB_SET: assert property (fsb_set_i |=>
    fsb_q[$past(fsb_idx_i)]) else $error("float register not busy");
  AST_SAVE_LEN: assert property ($rose(save_valid_o) |->
    save_valid_o [*8] ##1 save_valid_o [*8] ##1 save_valid_o [*4] ##1
    !save_valid_o) else $error("save stream length wrong");
  AST_CALL_LINK: assert property (call_i |=>
    loc_q[1] == $past(call_sp_i) && loc_q[2] == $past(call_rip_i))
    else $error("call linkage not seeded");
  AST_CALL_RET: assert property (call_i && depth_q < PW'(DEPTH)
    ##1 ret_i && !call_i |=> loc_q[5] == $past(loc_q[5], 2))
    else $error("locals not restored on return");
  AST_GLOB_KEEP: assert property ((call_i || ret_i) &&
    !(iwr_i.valid && !iwr_i.idx[4]) |=> glob_q[3] == $past(glob_q[3]))
    else $error("global changed across call");
  AST_FLT_EXT: assert property (fwr_i.valid &&
    fwr_i.fmt != prf_pkg::PRF_FMT_EXT |=> flt_q[$past(fwr_i.idx)][63])
    else $error("float result not widened");
endmodule

// >>> logic/prf_pkg.sv
// Package for the procedure register file: constants and carrier structs
package prf_pkg;
  localparam int unsigned WORD_W = 32;
  localparam int unsigned FLT_W = 80;
  localparam int unsigned NUM_GLOBAL = 16;
  localparam int unsigned NUM_LOCAL = 16;
  localparam int unsigned NUM_FLOAT = 4;
  localparam int unsigned NUM_INT = 32;
  localparam int unsigned FRAME_DEPTH = 8;
  // Integer register index: bit 4 clear selects globals, set selects locals
  localparam logic [4:0] GLOBAL_TOP_IDX = 5'h0f;
  localparam logic [4:0] LOCAL_ZERO_IDX = 5'h10;
  localparam logic [4:0] LOCAL_ONE_IDX = 5'h11;
  localparam logic [4:0] LOCAL_TWO_IDX = 5'h12;
  localparam logic [WORD_W-1:0] WORD_RST = 32'h0000_0000;
  localparam logic [FLT_W-1:0] FLT_RST = 80'h0;
  localparam logic [NUM_INT-1:0] SB_RST = 32'h0000_0000;
  localparam logic [1:0] SB_FLT_RST = 2'h0;
  localparam logic [3:0] FLT_BUSY_RST = 4'h0;
  localparam logic [14:0] EXT_BIAS = 15'h3c00;
  localparam logic [14:0] SGL_BIAS = 15'h3f80;
  localparam logic [4:0] SAVE_LAST = 5'h13;

  typedef enum logic [1:0] {
    PRF_FMT_SINGLE = 2'h0,
    PRF_FMT_DOUBLE = 2'h1,
    PRF_FMT_EXT = 2'h2
  } prf_fmt_t;

  // Integer access: base register and word count 1..4 (encoded count-1)
  typedef struct packed {
    logic valid;
    logic [4:0] idx;
    logic [1:0] len_m1;
  } prf_ref_t;

  typedef struct packed {
    logic valid;
    logic [1:0] idx;
    prf_fmt_t fmt;
    logic [FLT_W-1:0] data;
  } prf_fwr_t;

  typedef struct packed {
    logic valid;
    logic [4:0] idx;
    logic [1:0] len_m1;
    logic [4*WORD_W-1:0] data;
  } prf_iwr_t;
endpackage

// >>> dv/prf_load_model.sv
// Load unit model: marks its group busy unless the wait is zero, then writes back after a delay
module prf_load_model (
  input wire logic clk_i,
  input wire logic rst_b_i,
  input wire logic req_i,
  input wire logic [4:0] idx_i,
  input wire logic [1:0] len_i,
  input wire logic [127:0] data_i,
  input wire logic [3:0] wait_i,
  output prf_pkg::prf_ref_t sb_o,
  output prf_pkg::prf_iwr_t wr_o,
  output logic pend_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] cnt_q;
  logic [127:0] dat_q;
  always @(posedge clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      sb_o <= '0;
      wr_o <= '0;
      pend_o <= 1'b0;
      cnt_q <= 4'h0;
      dat_q <= '0;
    end
    else
    begin
      sb_o <= '0;
      wr_o.valid <= 1'b0;
      // Idle data keeps moving so a stale bus is never taken for valid
      wr_o.data <= ~wr_o.data;
      if (req_i)
      begin
        // Caller keeps bases aligned to the group size
        sb_o <= '{(wait_i != 4'h0), idx_i, len_i};
        wr_o.idx <= idx_i;
        wr_o.len_m1 <= len_i;
        dat_q <= data_i;
        cnt_q <= wait_i;
        pend_o <= 1'b1;
      end
      else if (pend_o && cnt_q > 4'h1)
        cnt_q <= cnt_q - 4'h1;
      else if (pend_o)
      begin
        wr_o.valid <= 1'b1;
        wr_o.data <= dat_q;
        pend_o <= 1'b0;
      end
    end
  end
endmodule

// >>> dv/procedure_register_file_tb.sv
// Self-checking bench for the procedure register file
module procedure_register_file_tb;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct packed {
    logic st;
    logic [127:0] m;
    logic [127:0] d;
  } prf_exp_t;
  localparam logic [127:0] ALL = '1;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  prf_pkg::prf_ref_t sa, sb, sbs;
  prf_pkg::prf_iwr_t iwr;
  prf_pkg::prf_fwr_t fwr;
  logic [1:0] fidx, rlen, fsbi;
  logic call, ret, susp, req, pend, save_v, stall, ovf, rd_q, fsb;
  logic [31:0] sp, return_instr_pointer, busy;
  logic [4:0] ridx, save_i;
  logic [3:0] rwait;
  logic [127:0] rdat, a_o, b_o;
  logic [79:0] f_o, save_d;
  logic [79:0] fx [4];
  logic [31:0] sh [32];
  logic [31:0] keep [16];
  prf_exp_t q [$];
  prf_exp_t e;
  logic [84:0] sq [$];
  int n_errors = 0;
  int comparisons = 0;
  always #10 clk = ~clk;
  prf_core #(.DEPTH(2)) prf_core_i (.core_clk_i(clk), .rst_b_i(rst_b),
    .src_a_i(sa), .src_b_i(sb), .iwr_i(iwr), .fsrc_idx_i(fidx),
    .fwr_i(fwr), .sb_set_i(sbs), .fsb_set_i(fsb), .fsb_idx_i(fsbi),
    .call_i(call), .ret_i(ret), .call_sp_i(sp), .call_rip_i(return_instr_pointer),
    .suspend_i(susp), .src_a_o(a_o), .src_b_o(b_o), .fsrc_o(f_o),
    .stall_o(stall), .busy_o(busy), .save_valid_o(save_v),
    .save_idx_o(save_i), .save_data_o(save_d), .frame_ovf_o(ovf));
  prf_load_model prf_load_model_i (.clk_i(clk), .rst_b_i(rst_b),
    .req_i(req), .idx_i(ridx), .len_i(rlen), .data_i(rdat),
    .wait_i(rwait), .sb_o(sbs), .wr_o(iwr), .pend_o(pend));
  task automatic finish_test;
    $display("comparisons %0d errors %0d", comparisons, n_errors);
    if (n_errors == 0 && comparisons > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  task automatic chk(input logic [127:0] s, x, m);
    comparisons++;
    if (((s ^ x) & m) !== 128'h0)
    begin
      n_errors++;
      $display("[FAIL] %0t saw %h expected %h", $time, s, x);
    end
  endtask
  task automatic pls(ref logic s);
    s = 1'b1;
    @(negedge clk);
    s = 1'b0;
    @(negedge clk);
  endtask
  // Both read ports get the same reference; results are noted first
  task automatic rd(input logic [4:0] i, input logic st, m);
    prf_exp_t x;
    x.st = st;
    x.m = {128{m}};
    for (int k = 0; k < 4; k++)
      x.d[32*k +: 32] = sh[{i[4], i[3:0] + 4'(k)}];
    q.push_back(x);
    sa = '{1'b1, i, 2'h3};
    sb = '{1'b1, i, 2'h3};
    @(negedge clk);
    sa = '0;
    sb = '0;
    @(negedge clk);
  endtask
  task automatic ld(input logic [4:0] i, input logic [3:0] w);
    for (int k = 0; k < 4; k++)
    begin
      rdat[32*k +: 32] = $urandom;
      sh[{i[4], i[3:0] + 4'(k)}] = rdat[32*k +: 32];
    end
    ridx = i;
    rlen = 2'h3;
    rwait = w;
    req = 1'b1;
    @(negedge clk);
    req = 1'b0;
    // The model drops a pending write-back if a new request comes at once
    @(negedge clk);
  endtask
  task automatic wt;
    for (int n = 0; n < 20 && pend; n++)
      @(negedge clk);
    if (pend)
    begin
      n_errors++;
      finish_test();
    end
    @(negedge clk);
  endtask
  task automatic fw(input logic [1:0] i, input prf_pkg::prf_fmt_t f,
    input logic [79:0] d, x);
    fwr = '{1'b1, i, f, d};
    fx[i] = x;
    @(negedge clk);
    fwr.valid = 1'b0;
    @(negedge clk);
  endtask
  always @(posedge clk)
    rd_q <= sa.valid;
  // Result watcher: takes the oldest note whenever a result shows
  always @(negedge clk)
  begin
    if (rd_q && q.size() > 0)
    begin
      e = q.pop_front();
      chk(a_o, e.d, e.m);
      chk(b_o, e.d, e.m);
      chk(128'(stall), 128'(e.st), 128'h1);
    end
    if (save_v && sq.size() > 0)
      chk(128'({save_i, save_d}), 128'(sq.pop_front()), ALL);
    else if (save_v)
      chk(128'h1, 128'h0, ALL);
  end
  initial
  begin
    {sa, sb, fwr, fidx, call, ret, susp, req, fsb, fsbi} = '0;
    {sp, return_instr_pointer, ridx, rlen, rwait, rdat} = '0;
    void'($urandom(78));
    repeat (2) @(negedge clk);
    rst_b = 1'b1;
    @(negedge clk);
    chk(128'({busy, ovf, save_v}), 128'h0, ALL);
    $display("test reset done");
    for (int b = 0; b < 32; b += 4)
      ld(5'(b), 4'h0);
    wt();
    for (int b = 0; b < 32; b += 4)
      rd(5'(b), 1'b0, 1'b1);
    rd(5'h1c, 1'b0, 1'b1);
    $display("test fill done");
    ld(5'h14, 4'h9);
    @(negedge clk);
    chk(128'(busy), 128'h00f0_0000, ALL);
    rd(5'h04, 1'b0, 1'b1);
    rd(5'h14, 1'b1, 1'b0);
    wt();
    chk(128'(busy), 128'h0, ALL);
    rd(5'h14, 1'b0, 1'b1);
    $display("test scoreboard done");
    sp = $urandom;
    return_instr_pointer = $urandom;
    for (int k = 0; k < 16; k++)
      keep[k] = sh[16+k];
    pls(call);
    sh[16] = sh[15];
    sh[17] = sp;
    sh[18] = return_instr_pointer;
    sh[19] = 32'h0;
    rd(5'h10, 1'b0, 1'b1);
    rd(5'h0c, 1'b0, 1'b1);
    pls(ret);
    for (int k = 0; k < 16; k++)
      sh[16+k] = keep[k];
    // Call directly followed by return must give back the caller's set
    call = 1'b1;
    @(negedge clk);
    call = 1'b0;
    ret = 1'b1;
    @(negedge clk);
    ret = 1'b0;
    for (int b = 16; b < 32; b += 4)
      rd(5'(b), 1'b0, 1'b1);
    pls(call);
    pls(call);
    chk(128'(ovf), 128'h0, ALL);
    pls(call);
    chk(128'(ovf), 128'h1, ALL);
    $display("test frames done");
    fw(2'h0, prf_pkg::PRF_FMT_SINGLE, 80'h3fc0_0000,
      80'h3fff_c000_0000_0000_0000);
    fw(2'h1, prf_pkg::PRF_FMT_DOUBLE, 80'hc008_0000_0000_0000,
      80'hc000_c000_0000_0000_0000);
    rdat[79:0] = {$urandom, $urandom, 16'($urandom)};
    fw(2'h2, prf_pkg::PRF_FMT_EXT, rdat[79:0], rdat[79:0]);
    fw(2'h3, prf_pkg::PRF_FMT_EXT, ~rdat[79:0], ~rdat[79:0]);
    for (int f = 0; f < 4; f++)
    begin
      fidx = 2'(f);
      @(negedge clk);
      chk(128'(f_o), 128'(fx[f]), ALL);
    end
    fsb = 1'b1;
    fsbi = 2'h1;
    @(negedge clk);
    fsb = 1'b0;
    fidx = 2'h1;
    @(negedge clk);
    chk(128'(stall), 128'h1, ALL);
    fw(2'h1, prf_pkg::PRF_FMT_EXT, fx[1], fx[1]);
    chk(128'(stall), 128'h0, ALL);
    $display("test float done");
    for (int k = 0; k < 20; k++)
      sq.push_back({5'(k), k < 16 ? 80'(sh[k]) : fx[k%4]});
    pls(susp);
    for (int n = 0; n < 40 && sq.size() > 0; n++)
      @(negedge clk);
    chk(128'(sq.size()), 128'h0, ALL);
    $display("test suspend done");
    finish_test();
  end
endmodule
